// ### logic/ast_pair_buf.sv
// two-entry buffer with valid/ready on both sides
`timescale 1ns/10ps
module ast_pair_buf #(
    parameter int unsigned WIDTH = 9
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    logic [WIDTH-1:0] mem_q [2];
    logic wr_q;
    logic rd_q;
    logic [1:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_q != 2'h2);
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o = mem_q[rd_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 2'h1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 2'h1;
            end
        end
    end
endmodule // ast_pair_buf

// ### logic/ast_serial_tx.sv
// asynchronous serial transmitter with flow control, pacing and permission timeout
// Functional notes
// - selector value 16 sends on the dedicated serial output instead of a pin.
// - the chosen transmit pin is made an output before sending.
// - a flow-control pin 0..15 is an input, sampled for send permission.
// - timeout exists only when flow control is on.
// - pacing together with flow control or timeout is refused.
// - pacing inserts an idle gap of a 16-bit count of 1 ms units.
// - timeout waits up to a 16-bit count of 1 ms or 0.4 ms, then aborts.
// - a 16-bit mode word sets bit period, data/parity bits and polarity.
// - bytes of any content and order are sent within one transmission.
// - both ends must use the same bit rate.
// - mode bits 0-11 period, 13 seven-bit even parity, 14 inverted, 15 open.
// - each character has one stop bit, 8N or 7E data.
// - dedicated output always sends inverted and driven, ignoring mode bits 14 and 15.
`timescale 1ns/10ps
`include "ast_params.svh"
module ast_serial_tx #(
    parameter int unsigned MS_CYCLES = `AST_MS_NS / `AST_CLK_PERIOD_NS,
    parameter int unsigned SHORT_CYCLES = `AST_SHORT_UNIT_NS / `AST_CLK_PERIOD_NS
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic start_i,
    input wire logic [4:0] tx_pin_sel_i,
    input wire logic flow_en_i,
    input wire logic [3:0] flow_pin_sel_i,
    input wire ast_pkg::ast_word_t mode_word_i,
    input wire logic pace_en_i,
    input wire ast_pkg::ast_word_t pace_i,
    input wire logic timeout_en_i,
    input wire ast_pkg::ast_word_t timeout_i,
    input wire logic timeout_short_unit_i,
    input wire ast_pkg::ast_byte_t byte_data_i,
    input wire logic byte_last_i,
    input wire logic byte_valid_i,
    output logic byte_ready_o,
    input wire logic [15:0] pin_in_i,
    output logic [15:0] pin_out_o,
    output logic [15:0] pin_oe_o,
    output logic dedicated_serial_out_o,
    output logic busy_o,
    output logic done_o,
    output logic timeout_o,
    output logic cfg_error_o
);
    import ast_pkg::*;

    localparam logic [16:0] MS_LEN = 17'(MS_CYCLES);
    localparam logic [16:0] SHORT_LEN = 17'(SHORT_CYCLES);

    function automatic logic [19:0] bit_cycles(input logic [11:0] cnt);
        bit_cycles = 20'((20'(cnt) + 20'(`AST_BIT_OFFSET)) * 20'(`AST_BIT_UNIT_CYC));
    endfunction

    function automatic logic [9:0] frame_of(input ast_byte_t d, input logic par7);
        if (par7) begin
            frame_of = {1'b1, ^d[6:0], d[6:0], 1'b0};
        end else begin
            frame_of = {1'b1, d, 1'b0};
        end
    endfunction

    ast_state_t state_q, state_d;
    logic [3:0] pin_q, fpin_q, bit_idx_q;
    logic pin_act_q, dedicated_q, flow_q, pace_en_q, to_en_q, short_q, inv_q, open_q, par7_q, last_q;
    ast_word_t pace_q, to_q, cnt_q;
    logic [19:0] period_q, baud_q;
    logic [15:0] meta_q, sync_q, pout_d, poe_d;
    logic [9:0] shift_q;
    logic [16:0] unit_q, unit_len;
    logic bit_end, grant, cfg_bad, load, pop, abort, fin, err, line, phys;
    logic [8:0] buf_data;
    logic buf_valid;

    ast_pair_buf #(.WIDTH(`AST_BUF_WIDTH)) u_buf (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .in_data_i({byte_last_i, byte_data_i}),
        .in_valid_i(byte_valid_i),
        .in_ready_o(byte_ready_o),
        .out_data_o(buf_data),
        .out_valid_o(buf_valid),
        .out_ready_i(pop)
    );

    assign cfg_bad = (pace_en_i && (flow_en_i || timeout_en_i))
        || (tx_pin_sel_i > `AST_DEDICATED_SEL);
    assign grant = sync_q[fpin_q] ^ inv_q;
    assign bit_end = (baud_q == period_q - 20'h1);
    assign unit_len = (state_q == ST_WAIT && short_q) ? SHORT_LEN : MS_LEN;

    always_comb begin
        state_d = state_q;
        load = 1'b0;
        pop = 1'b0;
        abort = 1'b0;
        fin = 1'b0;
        err = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                if (start_i) begin
                    if (cfg_bad) begin
                        err = 1'b1;
                        state_d = ST_DRAIN;
                    end else begin
                        state_d = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (buf_valid && (!flow_q || grant)) begin
                    load = 1'b1;
                    pop = 1'b1;
                    state_d = ST_SEND;
                end else if (flow_q && to_en_q && cnt_q >= to_q) begin
                    abort = 1'b1;
                    state_d = ST_DRAIN;
                end
            end
            ST_SEND: begin
                if (bit_end && bit_idx_q == 4'(`AST_FRAME_BITS - 1)) begin
                    if (last_q) begin
                        fin = 1'b1;
                        state_d = ST_IDLE;
                    end else begin
                        state_d = pace_en_q ? ST_GAP : ST_WAIT;
                    end
                end
            end
            ST_GAP: begin
                if (cnt_q >= pace_q) begin
                    state_d = ST_WAIT;
                end
            end
            ST_DRAIN: begin
                pop = buf_valid;
                if (buf_valid && buf_data[8]) begin
                    state_d = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // configuration latched when a transmission is accepted
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            pin_q <= 4'h0;
            pin_act_q <= 1'b0;
            dedicated_q <= 1'b0;
            flow_q <= 1'b0;
            fpin_q <= 4'h0;
            pace_en_q <= 1'b0;
            pace_q <= 16'h0000;
            to_en_q <= 1'b0;
            to_q <= 16'h0000;
            short_q <= 1'b0;
            inv_q <= 1'b1;
            open_q <= 1'b0;
            par7_q <= 1'b0;
            period_q <= bit_cycles(12'h000);
        end else if (state_q == ST_IDLE && start_i && !cfg_bad) begin
            dedicated_q <= (tx_pin_sel_i == `AST_DEDICATED_SEL);
            pin_q <= tx_pin_sel_i[3:0];
            pin_act_q <= pin_act_q || (tx_pin_sel_i != `AST_DEDICATED_SEL);
            flow_q <= flow_en_i;
            fpin_q <= flow_pin_sel_i;
            pace_en_q <= pace_en_i;
            pace_q <= pace_i;
            to_en_q <= timeout_en_i && flow_en_i;
            to_q <= timeout_i;
            short_q <= timeout_short_unit_i;
            if (tx_pin_sel_i == `AST_DEDICATED_SEL) begin
                inv_q <= 1'b1;
                open_q <= 1'b0;
            end else begin
                inv_q <= mode_word_i[`AST_INV_BIT];
                open_q <= mode_word_i[`AST_OPEN_BIT];
            end
            par7_q <= mode_word_i[`AST_PAR7_BIT];
            period_q <= bit_cycles(mode_word_i[`AST_PERIOD_HI:0]);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            meta_q <= 16'h0000;
            sync_q <= 16'h0000;
        end else begin
            meta_q <= pin_in_i;
            sync_q <= meta_q;
        end
    end

    // character shifter, one bit period per frame bit
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            shift_q <= 10'h3FF;
            bit_idx_q <= 4'h0;
            baud_q <= 20'h00000;
            last_q <= 1'b0;
        end else if (load) begin
            shift_q <= frame_of(buf_data[7:0], par7_q);
            bit_idx_q <= 4'h0;
            baud_q <= 20'h00000;
            last_q <= buf_data[8];
        end else if (state_q == ST_SEND) begin
            if (bit_end) begin
                baud_q <= 20'h00000;
                shift_q <= {1'b1, shift_q[9:1]};
                bit_idx_q <= bit_idx_q + 4'h1;
            end else begin
                baud_q <= baud_q + 20'h00001;
            end
        end
    end

    // millisecond or short-unit tick count for gap and timeout
    always_ff @(posedge ref_clk_i) begin
        if (srst_i || state_d != state_q) begin
            unit_q <= 17'h00000;
            cnt_q <= 16'h0000;
        end else if (unit_q == unit_len - 17'h00001) begin
            unit_q <= 17'h00000;
            if (cnt_q != 16'hFFFF) begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end else begin
            unit_q <= unit_q + 17'h00001;
        end
    end

    assign line = (state_q == ST_SEND) ? shift_q[0] : 1'b1;
    assign phys = line ^ inv_q;

    always_comb begin
        pout_d = 16'h0000;
        poe_d = 16'h0000;
        if (pin_act_q && !dedicated_q) begin
            pout_d[pin_q] = phys;
            poe_d[pin_q] = !open_q || line;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            pin_out_o <= 16'h0000;
            pin_oe_o <= 16'h0000;
            dedicated_serial_out_o <= 1'b0;
        end else begin
            pin_out_o <= pout_d;
            pin_oe_o <= poe_d;
            dedicated_serial_out_o <= dedicated_q ? phys : 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
            timeout_o <= 1'b0;
            cfg_error_o <= 1'b0;
        end else begin
            busy_o <= (state_d != ST_IDLE);
            done_o <= fin;
            timeout_o <= abort;
            cfg_error_o <= err;
        end
    end
endmodule // ast_serial_tx

// ### pkg/ast_params.svh
// timing constants and mode-word field positions for the serial transmitter
`ifndef AST_PARAMS_SVH
`define AST_PARAMS_SVH

`define AST_CLK_PERIOD_NS 10
`define AST_MS_NS 1000000
`define AST_SHORT_UNIT_NS 400000
`define AST_BIT_UNIT_NS 1000
`define AST_BIT_OFFSET 20
`define AST_BIT_UNIT_CYC (`AST_BIT_UNIT_NS / `AST_CLK_PERIOD_NS)
`define AST_PERIOD_HI 11
`define AST_PAR7_BIT 13
`define AST_INV_BIT 14
`define AST_OPEN_BIT 15
`define AST_DEDICATED_SEL 5'h10
`define AST_FRAME_BITS 10
`define AST_BUF_WIDTH 9

`endif

// ### pkg/ast_pkg.sv
// types shared by the serial transmitter modules
package ast_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT,
        ST_SEND,
        ST_GAP,
        ST_DRAIN
    } ast_state_t;

    typedef logic [7:0] ast_byte_t;
    typedef logic [15:0] ast_word_t;

endpackage

// ### tb/ast_rx_model.sv
// far-end receiver decoding one character at a time
`timescale 1ns/10ps
module ast_rx_model (
    input wire logic ref_clk_i,
    input wire logic line_i,
    input wire logic inv_i,
    input wire logic par7_i,
    input wire logic hold_i,
    input wire logic [31:0] period_i,
    output logic grant_o,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    output logic frame_ok_o
);
    logic [9:0] b;
    assign grant_o = inv_i ^ ~hold_i;
    initial begin
        rx_valid_o = 1'b0;
        rx_data_o = 8'h00;
        frame_ok_o = 1'b0;
        forever begin
            @(posedge ref_clk_i);
            rx_valid_o <= 1'b0;
            if ((line_i ^ inv_i) == 1'b0) begin
                repeat (period_i / 2) @(posedge ref_clk_i);
                for (int i = 0; i < 10; i++) begin
                    b[i] = line_i ^ inv_i;
                    if (i < 9) repeat (period_i) @(posedge ref_clk_i);
                end
                rx_data_o <= par7_i ? {1'b0, b[7:1]} : b[8:1];
                frame_ok_o <= !b[0] && b[9] && !(par7_i && ^b[8:1]);
                rx_valid_o <= 1'b1;
            end
        end
    end
endmodule // ast_rx_model

// ### tb/ast_serial_tx_asserts.sv
// port checker for the serial transmitter
`timescale 1ns/10ps
module ast_serial_tx_asserts (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic start_i,
    input wire logic [4:0] tx_pin_sel_i,
    input wire logic flow_en_i,
    input wire logic [3:0] flow_pin_sel_i,
    input wire ast_pkg::ast_word_t mode_word_i,
    input wire logic pace_en_i,
    input wire logic timeout_en_i,
    input wire logic [15:0] pin_oe_o,
    input wire logic dedicated_serial_out_o,
    input wire logic busy_o,
    input wire logic timeout_o,
    input wire logic cfg_error_o
);
    import ast_pkg::*;
    logic ded_q, last_q, flow_q;
    logic [4:0] sel_q;
    logic [3:0] fsel_q;
    int per_q, run_q;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    sequence s_acc;
        start_i && !busy_o;
    endsequence
    sequence s_gpio;
        s_acc ##0 tx_pin_sel_i < 5'h10 && !mode_word_i[15] && !pace_en_i;
    endsequence
    always_ff @(posedge ref_clk_i) begin
        last_q <= dedicated_serial_out_o;
        run_q <= (dedicated_serial_out_o != last_q) ? 1 : run_q + 1;
    end
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            ded_q <= 1'b0;
            flow_q <= 1'b0;
            sel_q <= 5'h00;
            fsel_q <= 4'h0;
            per_q <= 1;
        end else if (start_i && !busy_o) begin
            ded_q <= tx_pin_sel_i == 5'h10;
            flow_q <= flow_en_i;
            sel_q <= tx_pin_sel_i;
            fsel_q <= flow_pin_sel_i;
            per_q <= (int'(mode_word_i[11:0]) + 20) * 100;
        end
    end
    chk_cfg_refuse: assert property (s_acc ##0 pace_en_i && (flow_en_i || timeout_en_i) |=> cfg_error_o)
        else $error("mixed start not refused");
    chk_pin_range: assert property (s_acc ##0 tx_pin_sel_i > 5'h10 |=> cfg_error_o)
        else $error("bad pin not refused");
    chk_busy_rise: assert property (s_acc |=> busy_o)
        else $error("busy missing");
    chk_ded_idle: assert property ((!busy_o || !ded_q) |-> !dedicated_serial_out_o)
        else $error("dedicated line not idle");
    chk_oe_driven: assert property (s_gpio |-> ##[1:2] pin_oe_o[sel_q[3:0]])
        else $error("pin not driven");
    chk_flow_input: assert property (busy_o && flow_q && {1'b0, fsel_q} != sel_q |-> !pin_oe_o[fsel_q])
        else $error("flow pin driven");
    chk_timeout_flow: assert property (timeout_o |-> flow_q)
        else $error("timeout without flow pin");
    chk_bit_period: assert property (ded_q && last_q && !dedicated_serial_out_o |-> run_q % per_q == 0)
        else $error("bit length wrong");
endmodule // ast_serial_tx_asserts

bind ast_serial_tx ast_serial_tx_asserts chk_u (.*);

// ### tb/ast_serial_tx_tb.sv
// self-checking bench for the serial transmitter
`timescale 1ns/10ps
module ast_serial_tx_tb;
    import ast_pkg::*;
    logic ref_clk_i, srst_i, start_i, flow_en_i, pace_en_i, timeout_en_i, timeout_short_unit_i;
    logic byte_last_i, byte_valid_i, byte_ready_o, busy_o, done_o, timeout_o, cfg_error_o;
    logic dedicated_serial_out_o, hold, grant, inv_m, par7_m, line, rx_valid, frame_ok;
    logic [4:0] tx_pin_sel_i;
    logic [3:0] flow_pin_sel_i;
    ast_word_t mode_word_i, pace_i, timeout_i;
    ast_byte_t byte_data_i, rx_data;
    logic [15:0] pin_in_i, pin_out_o, pin_oe_o, rnd_pins;
    logic [31:0] rnd, per;
    localparam int MS = 20;
    int n_errors, compares, n_done, n_to, n_cfg;
    int cyc = 0, t_last = 0, t_gap = 0;
    ast_byte_t exp_q[$];
    assign pin_in_i = {rnd_pins[15:2], grant, rnd_pins[0]};
    // undriven pin rests at the idle level
    assign line = (tx_pin_sel_i == 5'h10) ? dedicated_serial_out_o : (pin_oe_o[3] ? pin_out_o[3] : ~inv_m);
    ast_serial_tx #(.MS_CYCLES(MS), .SHORT_CYCLES(8)) dut_u (.*);
    ast_rx_model rx_u (.ref_clk_i(ref_clk_i), .line_i(line), .inv_i(inv_m), .par7_i(par7_m), .hold_i(hold),
        .period_i(per), .grant_o(grant), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .frame_ok_o(frame_ok));
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    function automatic logic [31:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d, errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic ran_out();
        n_errors++;
        $display("Error at %0t: wait ran out", $time);
        finish_test();
    endtask
    task automatic wait_idle(input int lim);
        int k = 0;
        while (busy_o !== 1'b0 && k < lim) begin
            @(posedge ref_clk_i);
            #1;
            k++;
        end
        if (k >= lim) ran_out();
        // let the closing pulses reach the counters
        @(posedge ref_clk_i);
        #1;
    endtask
    task automatic offer(input ast_byte_t d, input logic last, input logic keep);
        int k = 0;
        byte_data_i = d;
        byte_last_i = last;
        byte_valid_i = 1'b1;
        if (keep) exp_q.push_back(par7_m ? d & 8'h7F : d);
        while (byte_ready_o !== 1'b1 && k < 5000) begin
            @(posedge ref_clk_i);
            #1;
            k++;
        end
        if (k >= 5000) ran_out();
        @(posedge ref_clk_i);
        #1;
        // a non-last byte keeps valid up for the next offer
        if (last) byte_valid_i = 1'b0;
    endtask
    task automatic go(input logic [4:0] sel, input ast_word_t mode, input logic fl, input logic pc, input logic to);
        tx_pin_sel_i = sel;
        mode_word_i = mode;
        flow_en_i = fl;
        pace_en_i = pc;
        timeout_en_i = to;
        inv_m = (sel == 5'h10) | mode[14];
        par7_m = mode[13];
        per = (32'(mode[11:0]) + 20) * 100;
        start_i = 1'b1;
        @(posedge ref_clk_i);
        #1;
        start_i = 1'b0;
    endtask
    always @(posedge ref_clk_i) begin
        #1;
        rnd_pins = 16'(xs());
    end
    always @(posedge ref_clk_i) begin
        if (done_o === 1'b1) n_done <= n_done + 1;
        if (timeout_o === 1'b1) n_to <= n_to + 1;
        if (cfg_error_o === 1'b1) n_cfg <= n_cfg + 1;
        if (rx_valid && exp_q.size() == 0) check({8'h01, rx_data}, 16'h0000);
        else if (rx_valid) check({7'h00, frame_ok, rx_data}, {8'h01, exp_q.pop_front()});
        // start-to-start spacing of received frames
        cyc <= cyc + 1;
        if (rx_valid) t_last <= cyc;
        if (rx_valid) t_gap <= cyc - t_last;
    end
    initial begin
        rnd = 32'h000018D7;
        rnd_pins = 16'h0000;
        n_errors = 0;
        compares = 0;
        n_done = 0;
        n_to = 0;
        n_cfg = 0;
        {srst_i, hold, inv_m} = 3'h5;
        {start_i, flow_en_i, pace_en_i, timeout_en_i, timeout_short_unit_i, par7_m} = 6'h00;
        {byte_last_i, byte_valid_i, byte_data_i, flow_pin_sel_i} = 14'h0000;
        {tx_pin_sel_i, mode_word_i, pace_i, timeout_i} = {5'h10, 48'h0};
        per = 32'h000007D0;
        repeat (8) @(posedge ref_clk_i);
        #1;
        srst_i = 1'b0;
        go(5'h10, 16'h8000, 1'b0, 1'b0, 1'b0);
        offer(8'(xs()), 1'b1, 1'b1);
        wait_idle(30000);
        check(16'(n_done), 16'h0001);
        $display("test dedicated line done");
        hold = 1'b1;
        flow_pin_sel_i = 4'h1;
        go(5'h03, 16'h6000, 1'b1, 1'b0, 1'b0);
        offer(8'(xs()) | 8'h80, 1'b1, 1'b1);
        repeat (100) @(posedge ref_clk_i);
        #1;
        check(16'(line ^ inv_m), 16'h0001);
        check(16'(pin_oe_o[1]), 16'h0000);
        hold = 1'b0;
        wait_idle(30000);
        check(16'(n_done), 16'h0002);
        $display("test flow gating done");
        for (int i = 0; i < 3; i++) begin
            go(i == 2 ? 5'h14 : 5'h10, 16'h4000, i == 0, i < 2, i == 1);
            offer(8'(xs()), 1'b1, 1'b0);
            wait_idle(200);
            check(16'(n_cfg), 16'(i + 1));
        end
        $display("test refusals done");
        hold = 1'b1;
        // three 0.4 ms units first, then one 1 ms unit
        for (int j = 0; j < 2; j++) begin
            timeout_i = (j == 0) ? 16'h0003 : 16'h0001;
            timeout_short_unit_i = (j == 0);
            go(5'h10, 16'h0000, 1'b1, 1'b0, 1'b1);
            offer(8'(xs()), 1'b1, 1'b0);
            repeat (18) @(posedge ref_clk_i);
            #1;
            check(16'(n_to), 16'(j));
            wait_idle(200);
            check(16'(n_to), 16'(j + 1));
        end
        hold = 1'b0;
        $display("test timeout done");
        pace_i = 16'h0002;
        go(5'h10, 16'h0000, 1'b0, 1'b1, 1'b0);
        offer(8'(xs()), 1'b0, 1'b1);
        offer(8'(xs()), 1'b1, 1'b1);
        wait_idle(50000);
        check(16'(n_done), 16'h0003);
        check(16'(exp_q.size()), 16'h0000);
        check(16'(t_gap >= 10 * per + pace_i * MS && t_gap <= 10 * per + pace_i * MS + 4), 16'h0001);
        $display("test pacing done");
        finish_test();
    end
endmodule // ast_serial_tx_tb
